// [core/flcb_pkg.sv]
package flcb_pkg;
  localparam int NUM_LOCK = 256;
  localparam int REGION_BYTES = 8192;
  localparam int PAGE_BYTES = 512;
  localparam int SECTOR_PAGES = 128;
  localparam int PAGES_PER_REG = REGION_BYTES / PAGE_BYTES;
  localparam int NUM_PLANES = 2;
  localparam int SIG_WORDS = PAGE_BYTES / 4;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_RES = 8'h08;
  localparam logic [7:0] OFS_LSEL = 8'h0C;
  localparam logic [7:0] OFS_LWRD = 8'h10;
  localparam logic [7:0] OFS_UID0 = 8'h14;
  localparam logic [7:0] OFS_CPCTL = 8'h24;
  localparam logic [7:0] OFS_WAIT = 8'h28;
  localparam logic [7:0] OFS_SADR = 8'h2C;
  localparam logic [7:0] OFS_SDAT = 8'h30;
  localparam logic [7:0] CMD_WP = 8'h01;
  localparam logic [7:0] CMD_EP = 8'h02;
  localparam logic [7:0] CMD_EA = 8'h03;
  localparam logic [7:0] CMD_SLB = 8'h08;
  localparam logic [7:0] CMD_CLB = 8'h09;
  localparam logic [7:0] CMD_SGB = 8'h0B;
  localparam logic [7:0] CMD_CGB = 8'h0C;
  localparam logic [7:0] CMD_DESC = 8'h0E;
  localparam logic [7:0] CMD_SERA = 8'h14;
  localparam logic [7:0] CMD_SWEN = 8'h15;
  localparam logic [7:0] CMD_SWDI = 8'h16;
  localparam logic [1:0] FOP_WRITE = 2'h1;
  localparam logic [1:0] FOP_ERASE = 2'h2;
  localparam logic [1:0] FOP_ALL = 2'h3;
  localparam int CFG_SEC = 0;
  localparam int CFG_BOOT = 1;
  localparam int CFG_PLANE = 2;
  localparam int CP_BUSCLK = 0;
  localparam int CP_CORECLK = 1;
  localparam int CP_BUSRST = 2;
  localparam int CP_RAMCLK = 3;
  localparam int CP_CORERST = 4;
  localparam logic [4:0] CP_RESET = 5'h14;
  localparam logic [3:0] WAIT_RESET = 4'h5;
  localparam logic [2:0] DESC_LAST = 3'h4;
  localparam logic [31:0] SIG_BLANK = 32'hFFFFFFFF;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_MASS} flcb_fsm_t;
endpackage : flcb_pkg

// [core/flcb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module flcb_top
  import flcb_pkg::*;
#(
  // Identifier value is arbitrary.
  parameter logic [127:0] UID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        nv_blank_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        erase_pin_i,
  input  wire logic        ppp_valid_i,
  input  wire logic [7:0]  ppp_cmd_i,
  input  wire logic [15:0] ppp_arg_i,
  output logic             ppp_ack_o,
  output logic             ppp_err_o,
  input  wire logic        flash_done_i,
  output logic             flash_req_o,
  output logic      [1:0]  flash_op_o,
  output logic      [11:0] flash_page_o,
  output logic             secure_o,
  output logic             boot_flash_o,
  output logic             boot_plane_o,
  output logic             cp_bus_clk_en_o,
  output logic             cp_core_clk_en_o,
  output logic             cp_bus_rst_o,
  output logic             cp_ram_clk_en_o,
  output logic             cp_core_rst_o,
  output logic             cp_boot_code_ram_o,
  output logic      [3:0]  wait_states_o
);

  typedef struct packed {
    flcb_fsm_t               fsm;
    logic                    ack;
    logic [31:0]             dat;
    logic [NUM_LOCK-1:0]     lock;
    logic [2:0]              nv_cfg;
    logic [2:0]              act_cfg;
    logic                    lock_err;
    logic                    cmd_err;
    logic                    fl_req;
    logic [1:0]              fl_op;
    logic [11:0]             fl_page;
    logic [2:0]              desc_idx;
    logic [2:0]              lock_sel;
    logic [4:0]              cp;
    logic                    cp_run;
    logic [3:0]              wait_st;
    logic                    sig_wen;
    logic [6:0]              sig_adr;
    logic [SIG_WORDS-1:0][31:0] sig;
    logic                    ppp_ack;
    logic                    ppp_err;
  } flcb_state_t;

  flcb_state_t st_reg;
  flcb_state_t st_next;

  logic        bus_go;
  logic        bus_wr;
  logic        cmd_wr;
  logic        mass_go;
  logic        c_go;
  logic        p_go;
  logic        exec;
  logic        mass_done;
  logic [7:0]  cmd;
  logic [11:0] arg;
  logic [1:0]  uid_idx;

  // A page maps to its lock region by dropping the page-within-region bits.
  function automatic logic page_locked(input logic [NUM_LOCK-1:0] lk,
                                       input logic [11:0] pg);
    page_locked = lk[pg[11:4]];
  endfunction : page_locked

  function automatic logic [31:0] desc_word(input logic [2:0] idx);
    unique case (idx)
      3'h0:    desc_word = 32'(NUM_PLANES);
      3'h1:    desc_word = 32'(PAGE_BYTES);
      3'h2:    desc_word = 32'(SECTOR_PAGES);
      3'h3:    desc_word = 32'(REGION_BYTES);
      3'h4:    desc_word = 32'(NUM_LOCK);
      default: desc_word = 32'h00000000;
    endcase
  endfunction : desc_word

  assign bus_go    = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign bus_wr    = bus_go & wb_we_i & (wb_sel_i == 4'hF);
  assign cmd_wr    = bus_wr & (wb_adr_i == OFS_CMD);
  assign mass_go   = erase_pin_i & (st_reg.fsm == ST_IDLE);
  assign c_go      = cmd_wr & ~mass_go & (st_reg.fsm == ST_IDLE);
  // The request is still up while its ack stands, so that cycle must not take it again.
  assign p_go      = ppp_valid_i & ~st_reg.ppp_ack & ~cmd_wr & ~mass_go & (st_reg.fsm == ST_IDLE);
  assign exec      = c_go | (p_go & ~st_reg.act_cfg[CFG_SEC]);
  assign mass_done = (st_reg.fsm == ST_MASS) & flash_done_i;
  assign cmd       = c_go ? wb_dat_i[7:0] : ppp_cmd_i;
  assign arg       = c_go ? wb_dat_i[27:16] : ppp_arg_i[11:0];
  assign uid_idx   = wb_adr_i[3:2] - OFS_UID0[3:2];

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.ppp_ack = 1'b0;
    st_next.ppp_err = 1'b0;
    if (bus_go) begin
      st_next.ack = 1'b1;
      st_next.dat = 32'h00000000;
      if (!wb_we_i) begin
        if (wb_adr_i == OFS_STAT) begin
          st_next.dat = {25'h0000000, st_reg.sig_wen, st_reg.act_cfg,
                         st_reg.cmd_err, st_reg.lock_err, st_reg.fsm == ST_IDLE};
          // Errors clear on read; a new error below still lands.
          st_next.lock_err = 1'b0;
          st_next.cmd_err = 1'b0;
        end else if (wb_adr_i == OFS_RES) begin
          st_next.dat = desc_word(st_reg.desc_idx);
          if (st_reg.desc_idx != DESC_LAST) begin
            st_next.desc_idx = st_reg.desc_idx + 3'h1;
          end
        end else if (wb_adr_i == OFS_LSEL) begin
          st_next.dat = {29'h00000000, st_reg.lock_sel};
        end else if (wb_adr_i == OFS_LWRD) begin
          st_next.dat = st_reg.lock[st_reg.lock_sel*32 +: 32];
        end else if (wb_adr_i[7:4] == OFS_UID0[7:4] || wb_adr_i[7:2] == 6'h08) begin
          if (wb_adr_i >= OFS_UID0 && wb_adr_i < OFS_CPCTL) begin
            st_next.dat = UID[uid_idx*32 +: 32];
          end
        end else if (wb_adr_i == OFS_CPCTL) begin
          st_next.dat = {27'h0000000, st_reg.cp};
        end else if (wb_adr_i == OFS_WAIT) begin
          st_next.dat = {28'h0000000, st_reg.wait_st};
        end else if (wb_adr_i == OFS_SADR) begin
          st_next.dat = {25'h0000000, st_reg.sig_adr};
        end else if (wb_adr_i == OFS_SDAT) begin
          st_next.dat = st_reg.sig[st_reg.sig_adr];
          st_next.sig_adr = st_reg.sig_adr + 7'h01;
        end
      end else if (bus_wr) begin
        if (wb_adr_i == OFS_LSEL) begin
          st_next.lock_sel = wb_dat_i[2:0];
        end else if (wb_adr_i == OFS_CPCTL) begin
          // Ordering of these steps is left to software.
          st_next.cp = wb_dat_i[4:0];
          st_next.cp_run = ~wb_dat_i[CP_CORERST];
        end else if (wb_adr_i == OFS_WAIT) begin
          st_next.wait_st = wb_dat_i[3:0];
        end else if (wb_adr_i == OFS_SADR) begin
          st_next.sig_adr = wb_dat_i[6:0];
        end else if (wb_adr_i == OFS_SDAT && st_reg.sig_wen) begin
          st_next.sig[st_reg.sig_adr] = wb_dat_i;
          st_next.sig_adr = st_reg.sig_adr + 7'h01;
        end
      end
    end
    if (cmd_wr && !c_go) begin
      st_next.cmd_err = 1'b1;
    end
    if (p_go) begin
      st_next.ppp_ack = 1'b1;
      st_next.ppp_err = st_reg.act_cfg[CFG_SEC];
    end
    if (exec) begin
      unique case (cmd)
        CMD_WP, CMD_EP: begin
          if (page_locked(st_reg.lock, arg)) begin
            st_next.lock_err = 1'b1;
          end else begin
            st_next.fsm = ST_BUSY;
            st_next.fl_req = 1'b1;
            st_next.fl_op = (cmd == CMD_WP) ? FOP_WRITE : FOP_ERASE;
            st_next.fl_page = arg;
          end
        end
        CMD_EA: begin
          if (|st_reg.lock) begin
            st_next.lock_err = 1'b1;
          end else begin
            st_next.fsm = ST_BUSY;
            st_next.fl_req = 1'b1;
            st_next.fl_op = FOP_ALL;
          end
        end
        CMD_SLB: st_next.lock[arg[7:0]] = 1'b1;
        CMD_CLB: st_next.lock[arg[7:0]] = 1'b0;
        CMD_SGB, CMD_CGB: begin
          // Security never clears by command; only a completed mass erase or a reset with nv_blank_i high drops it.
          if (arg > 12'h002 || (cmd == CMD_CGB && arg == 12'h000)) begin
            st_next.cmd_err = 1'b1;
          end else begin
            st_next.nv_cfg[arg[1:0]] = (cmd == CMD_SGB);
          end
        end
        CMD_DESC: st_next.desc_idx = 3'h0;
        CMD_SERA: st_next.sig = {SIG_WORDS{SIG_BLANK}};
        CMD_SWEN: st_next.sig_wen = 1'b1;
        CMD_SWDI: st_next.sig_wen = 1'b0;
        default:  st_next.cmd_err = 1'b1;
      endcase
    end
    unique case (st_reg.fsm)
      ST_IDLE: begin
        if (mass_go) begin
          st_next.lock = '0;
          st_next.nv_cfg[CFG_BOOT] = 1'b0;
          st_next.fsm = ST_MASS;
          st_next.fl_req = 1'b1;
          st_next.fl_op = FOP_ALL;
        end
      end
      ST_BUSY: begin
        if (flash_done_i) begin
          st_next.fl_req = 1'b0;
          st_next.fsm = ST_IDLE;
        end
      end
      ST_MASS: begin
        if (flash_done_i) begin
          st_next.fl_req = 1'b0;
          st_next.fsm = ST_IDLE;
          // Security drops at once so access returns without a reset.
          st_next.nv_cfg[CFG_SEC] = 1'b0;
          st_next.act_cfg[CFG_SEC] = 1'b0;
        end
      end
    endcase
    if (rst_i) begin
      // Locks, config bits and signature are nonvolatile and survive any reset taken with nv_blank_i low.
      st_next.fsm = ST_IDLE;
      st_next.ack = 1'b0;
      st_next.dat = 32'h00000000;
      st_next.lock_err = 1'b0;
      st_next.cmd_err = 1'b0;
      st_next.fl_req = 1'b0;
      st_next.fl_op = 2'h0;
      st_next.fl_page = 12'h000;
      st_next.desc_idx = 3'h0;
      st_next.lock_sel = 3'h0;
      st_next.cp = CP_RESET;
      st_next.cp_run = ~CP_RESET[CP_CORERST];
      st_next.wait_st = WAIT_RESET;
      st_next.sig_wen = 1'b0;
      st_next.sig_adr = 7'h00;
      st_next.ppp_ack = 1'b0;
      st_next.ppp_err = 1'b0;
      if (nv_blank_i) begin
        st_next.lock = '0;
        st_next.nv_cfg = 3'h0;
        st_next.sig = {SIG_WORDS{SIG_BLANK}};
      end
      st_next.act_cfg = nv_blank_i ? 3'h0 : st_reg.nv_cfg;
    end
  end

  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  assign wb_dat_o           = st_reg.dat;
  assign wb_ack_o           = st_reg.ack;
  assign ppp_ack_o          = st_reg.ppp_ack;
  assign ppp_err_o          = st_reg.ppp_err;
  assign flash_req_o        = st_reg.fl_req;
  assign flash_op_o         = st_reg.fl_op;
  assign flash_page_o       = st_reg.fl_page;
  assign secure_o           = st_reg.act_cfg[CFG_SEC];
  assign boot_flash_o       = st_reg.act_cfg[CFG_BOOT];
  assign boot_plane_o       = st_reg.act_cfg[CFG_PLANE];
  assign cp_bus_clk_en_o    = st_reg.cp[CP_BUSCLK];
  assign cp_core_clk_en_o   = st_reg.cp[CP_CORECLK];
  assign cp_bus_rst_o       = st_reg.cp[CP_BUSRST];
  assign cp_ram_clk_en_o    = st_reg.cp[CP_RAMCLK];
  assign cp_core_rst_o      = st_reg.cp[CP_CORERST];
  assign cp_boot_code_ram_o = st_reg.cp_run;
  assign wait_states_o      = st_reg.wait_st;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_mass_start;
    erase_pin_i && st_reg.fsm == ST_IDLE;
  endsequence

  sequence s_mass_cleared;
    st_reg.lock == '0 && !st_reg.nv_cfg[CFG_BOOT] && st_reg.fsm == ST_MASS;
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ppp_ack_single: assert property (ppp_ack_o |=> !ppp_ack_o)
    else $error("programming port ack held longer than one cycle");
  a_mass_clears_locks: assert property (s_mass_start |=> s_mass_cleared)
    else $error("mass erase did not clear locks and boot bit");
  a_sec_clear_cause: assert property ($fell(st_reg.nv_cfg[CFG_SEC]) |-> $past(mass_done))
    else $error("security cleared without completed mass erase");
  a_sec_set_cause: assert property ($rose(st_reg.nv_cfg[CFG_SEC]) |->
      $past(exec) && $past(cmd) == CMD_SGB && $past(arg) == 12'h000)
    else $error("security set by a path other than its command");
  a_lock_refuse: assert property (exec && (cmd == CMD_WP || cmd == CMD_EP) &&
      page_locked(st_reg.lock, arg) |=> st_reg.lock_err && !flash_req_o)
    else $error("locked page write was not refused");
  a_ppp_secure_block: assert property (p_go && secure_o |=> ppp_ack_o && ppp_err_o && !flash_req_o)
    else $error("programming port reached flash while secure");
  a_cp_held_reset: assert property ($fell(rst_i) |-> cp_core_rst_o && cp_bus_rst_o && !cp_core_clk_en_o)
    else $error("coprocessor not held after reset");
  a_boot_sampled: assert property ($fell(rst_i) && !$past(nv_blank_i) |->
      st_reg.act_cfg == $past(st_reg.nv_cfg))
    else $error("config bits not sampled at reset");
  a_mass_end_open: assert property (mass_done |=> !secure_o && st_reg.fsm == ST_IDLE)
    else $error("access not restored after mass erase");

endmodule : flcb_top
`default_nettype wire

// [testbench/flcb_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
module flcb_flash_model (
  input  wire logic clk_i,
  input  wire logic req_i,
  input  wire logic slow_i,
  output logic      done_o
);
  logic [5:0] cnt_reg = 6'h00;
  // The array answers once per request; the slow setting stands in for a long full erase.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (req_i !== 1'b1) begin
      cnt_reg <= 6'h00;
    end else if (cnt_reg == (slow_i ? 6'h14 : 6'h02)) begin
      done_o  <= 1'b1;
      cnt_reg <= cnt_reg + 6'h01;
    end else if (cnt_reg < 6'h15) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end
endmodule : flcb_flash_model
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench
  import flcb_pkg::*;
;
  // Identifier value is arbitrary.
  localparam logic [127:0] TB_UID = 128'h00112233445566778899AABBCCDDEEFF;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} flcb_row_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, nv_blank_i = 1'b1, slow_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, erase_pin_i = 1'b0, ppp_valid_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, ppp_cmd_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [15:0] ppp_arg_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, ppp_ack_o, ppp_err_o, flash_done_i, flash_req_o, secure_o, boot_flash_o, boot_plane_o;
  logic        cp_bus_clk_en_o, cp_core_clk_en_o, cp_bus_rst_o, cp_ram_clk_en_o, cp_core_rst_o, cp_boot_code_ram_o;
  logic [1:0]  flash_op_o;
  logic [11:0] flash_page_o;
  logic [3:0]  wait_states_o;
  logic [4:0]  cp_seq [5] = '{5'h15, 5'h17, 5'h13, 5'h1B, 5'h0B};
  int          bad_count = 0, n_tests = 0;
  flcb_row_t   rows [16] = '{
    '{8'h24, 1'b0, 32'h0, 32'h14}, '{8'h28, 1'b0, 32'h0, 32'h5}, '{8'h28, 1'b1, 32'h3, 32'h0},
    '{8'h28, 1'b0, 32'h0, 32'h3}, '{8'h14, 1'b0, 32'h0, TB_UID[31:0]}, '{8'h18, 1'b0, 32'h0, TB_UID[63:32]},
    '{8'h1C, 1'b0, 32'h0, TB_UID[95:64]}, '{8'h20, 1'b0, 32'h0, TB_UID[127:96]},
    '{8'h08, 1'b0, 32'h0, 32'h2}, '{8'h08, 1'b0, 32'h0, 32'h200}, '{8'h08, 1'b0, 32'h0, 32'h80},
    '{8'h08, 1'b0, 32'h0, 32'h2000}, '{8'h08, 1'b0, 32'h0, 32'h100}, '{8'h08, 1'b0, 32'h0, 32'h100},
    '{8'h3C, 1'b0, 32'h0, 32'h0}, '{8'hFC, 1'b0, 32'h0, 32'h0}};

  always #20 clk_i = ~clk_i;

  flcb_top #(.UID(TB_UID)) DUT (
    .clk_i, .rst_i, .nv_blank_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .erase_pin_i, .ppp_valid_i, .ppp_cmd_i, .ppp_arg_i, .ppp_ack_o, .ppp_err_o, .flash_done_i,
    .flash_req_o, .flash_op_o, .flash_page_o, .secure_o, .boot_flash_o, .boot_plane_o, .cp_bus_clk_en_o,
    .cp_core_clk_en_o, .cp_bus_rst_o, .cp_ram_clk_en_o, .cp_core_rst_o, .cp_boot_code_ram_o, .wait_states_o);

  flcb_flash_model FLASH (.clk_i(clk_i), .req_i(flash_req_o), .slow_i(slow_i), .done_o(flash_done_i));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The request is held until the edge that samples ack, and only then released.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check("wb ack", wb_ack_o, 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    #1;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, 4'hF, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(a, 1'b0, 32'h0, 4'hF, r);
  endtask : rd

  task automatic cmd(input logic [7:0] c, input logic [11:0] arg);
    wr(OFS_CMD, {4'h0, arg, 8'h00, c});
  endtask : cmd

  task automatic ppp(input logic [7:0] c, input logic [15:0] a, input logic exp_err);
    int n;
    @(posedge clk_i);
    ppp_valid_i <= 1'b1;
    ppp_cmd_i   <= c;
    ppp_arg_i   <= a;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ppp_ack_o !== 1'b1 && n < 20);
    check("ppp ack", ppp_ack_o, 1'b1);
    check("ppp err", ppp_err_o, exp_err);
    ppp_valid_i <= 1'b0;
  endtask : ppp

  task automatic rst(input logic blank);
    @(posedge clk_i);
    rst_i      <= 1'b1;
    nv_blank_i <= blank;
    repeat (3) @(posedge clk_i);
    rst_i      <= 1'b0;
    nv_blank_i <= 1'b0;
    #1;
    check("cp after reset", {cp_bus_rst_o, cp_core_rst_o, cp_bus_clk_en_o, cp_core_clk_en_o, cp_ram_clk_en_o}, 5'h18);
    check("wait states", wait_states_o, 4'h5);
  endtask : rst

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    rst(1'b1);
    check("blank config", {secure_o, boot_flash_o, boot_plane_o}, 3'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, q);
        check($sformatf("reg %h", rows[i].a), q, rows[i].e);
      end
    end
    cmd(CMD_DESC, 12'h000);
    rd(OFS_RES, q);
    check("descriptor restart", q, 32'h2);
    wb(OFS_WAIT, 1'b1, 32'h9, 4'h3, q);
    rd(OFS_WAIT, q);
    check("partial write ignored", q, 32'h3);
    $display("register table test done");
    // Start order kept by software: bus clock, core clock, bus reset, RAM clock, core reset.
    foreach (cp_seq[i]) begin
      wr(OFS_CPCTL, {27'h0, cp_seq[i]});
      check("cp core reset", cp_core_rst_o, i < 4);
    end
    check("cp running", {cp_bus_rst_o, cp_bus_clk_en_o, cp_core_clk_en_o, cp_ram_clk_en_o}, 4'h7);
    check("cp code ram boot", cp_boot_code_ram_o, 1'b1);
    $display("coprocessor test done");
    cmd(CMD_SWEN, 12'h000);
    wr(OFS_SADR, 32'h0);
    wr(OFS_SDAT, 32'hA5A50F0F);
    wr(OFS_SADR, 32'h0);
    rd(OFS_SDAT, q);
    check("signature word", q, 32'hA5A50F0F);
    cmd(CMD_SLB, 12'h003);
    wr(OFS_LSEL, 32'h0);
    rd(OFS_LWRD, q);
    check("lock word", q, 32'h8);
    cmd(CMD_WP, 12'h032);
    repeat (4) @(posedge clk_i);
    #1;
    check("locked write req", flash_req_o, 1'b0);
    rd(OFS_STAT, q);
    check("lock error flag", q[1], 1'b1);
    rd(OFS_STAT, q);
    check("lock error cleared", q[1], 1'b0);
    cmd(CMD_CLB, 12'h003);
    cmd(CMD_WP, 12'h032);
    for (int n = 0; n < 10 && flash_req_o !== 1'b1; n++) @(posedge clk_i);
    check("write op page", {flash_op_o, flash_page_o}, {FOP_WRITE, 12'h032});
    for (int n = 0; n < 20 && flash_req_o !== 1'b0; n++) @(posedge clk_i);
    cmd(CMD_SLB, 12'h005);
    cmd(CMD_EA, 12'h000);
    cmd(CMD_EP, 12'h050);
    rd(OFS_STAT, q);
    check("erase refused", {q[1], flash_req_o}, 2'h2);
    cmd(CMD_CLB, 12'h005);
    cmd(CMD_EP, 12'h051);
    check("erase op page", {flash_op_o, flash_page_o}, {FOP_ERASE, 12'h051});
    for (int n = 0; n < 20 && flash_req_o !== 1'b0; n++) @(posedge clk_i);
    $display("lock test done");
    cmd(CMD_SGB, 12'h000);
    cmd(CMD_SGB, 12'h001);
    cmd(CMD_SGB, 12'h002);
    rst(1'b0);
    check("stored config", {secure_o, boot_flash_o, boot_plane_o}, 3'h7);
    rd(OFS_STAT, q);
    check("status config", q[5:3], 3'h7);
    ppp(CMD_SLB, 16'h0002, 1'b1);
    rd(OFS_LWRD, q);
    check("lock while secure", q, 32'h0);
    cmd(CMD_CGB, 12'h000);
    rd(OFS_STAT, q);
    check("clear security refused", q[2], 1'b1);
    rst(1'b0);
    check("secure kept", secure_o, 1'b1);
    $display("security test done");
    slow_i <= 1'b1;
    @(posedge clk_i);
    erase_pin_i <= 1'b1;
    for (int n = 0; n < 10 && flash_req_o !== 1'b1; n++) @(posedge clk_i);
    check("mass erase op", flash_op_o, FOP_ALL);
    erase_pin_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("secure before done", secure_o, 1'b1);
    for (int n = 0; n < 60 && secure_o !== 1'b0; n++) @(posedge clk_i);
    check("secure after erase", secure_o, 1'b0);
    rd(OFS_LWRD, q);
    check("locks after erase", q, 32'h0);
    ppp(CMD_SLB, 16'h0001, 1'b0);
    rd(OFS_LWRD, q);
    check("port lock after erase", q, 32'h2);
    rd(OFS_UID0, q);
    check("uid after erase", q, TB_UID[31:0]);
    wr(OFS_SADR, 32'h0);
    rd(OFS_SDAT, q);
    check("signature after erase", q, 32'hA5A50F0F);
    cmd(CMD_SWEN, 12'h000);
    cmd(CMD_SWDI, 12'h000);
    wr(OFS_SADR, 32'h0);
    wr(OFS_SDAT, 32'h12345678);
    wr(OFS_SADR, 32'h0);
    rd(OFS_SDAT, q);
    check("signature write locked", q, 32'hA5A50F0F);
    cmd(CMD_SERA, 12'h000);
    wr(OFS_SADR, 32'h0);
    rd(OFS_SDAT, q);
    check("signature erased", q, SIG_BLANK);
    cmd(CMD_CGB, 12'h002);
    rst(1'b0);
    check("config after erase", {secure_o, boot_flash_o, boot_plane_o}, 3'h0);
    $display("mass erase test done");
    results();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    $display("ERROR watchdog expected finish seen timeout");
    results();
  end
endmodule : testbench
`default_nettype wire
